// ### verilog/alu_ops_map.vh
`ifndef ALU_OPS_MAP_VH
`define ALU_OPS_MAP_VH
// Operation codes presented on op_code_in.
`define OP_SIGNED_DIVIDE      5'h00
`define OP_COMPARE_OP         5'h01
`define OP_NEGATE             5'h02
`define OP_ZERO_EXTEND        5'h03
`define OP_SIGN_EXTEND        5'h04
`define OP_AND                5'h05
`define OP_OR                 5'h06
`define OP_XOR                5'h07
`define OP_NOT                5'h08
`define OP_ARITH_SHIFT_LEFT   5'h09
`define OP_ARITH_SHIFT_RIGHT  5'h0A
`define OP_LOGIC_SHIFT_LEFT   5'h0B
`define OP_LOGIC_SHIFT_RIGHT  5'h0C
`define OP_ROTATE_LEFT        5'h0D
`define OP_ROTATE_RIGHT       5'h0E
`define OP_ROTATE_CARRY_LEFT  5'h0F
`define OP_ROTATE_CARRY_RIGHT 5'h10
`define OP_BIT_SET            5'h11
`define OP_BIT_CLEAR          5'h12
`define OP_BIT_INVERT         5'h13
`define OP_BIT_TEST           5'h14
`define OP_BIT_AND_CARRY      5'h15
`define OP_INV_BIT_AND_CARRY  5'h16
`define OP_BIT_OR_CARRY       5'h17
`define OP_INV_BIT_OR_CARRY   5'h18
`define OP_BIT_XOR_CARRY      5'h19
`define OP_INV_BIT_XOR_CARRY  5'h1A
// Operand size codes on size_in.
`define SIZE_BYTE             2'h0
`define SIZE_WORD             2'h1
`define SIZE_LONG             2'h2
// Flag bit positions within condition_flags.
`define FLAG_C                0
`define FLAG_V                1
`define FLAG_Z                2
`define FLAG_N                3
`define FLAGS_RESET           4'h0
`endif

// ### verilog/alu_datapath.v
`timescale 1ns/100ps
// Behaviour
// - Signed divide 16/8 and 32/16 bits
// - Compare subtracts source, sets flags only
// - Negate gives zero minus destination
// - Zero extend low byte or word
// - Sign extend low byte or word
// - AND, OR, XOR with register or immediate
// - Complement inverts the destination bits within the operand size
// - Arithmetic shifts keep sign on right
// - Logical shifts insert zeros
// - Rotate feeds out bit to other end
// - Rotate through carry as extra bit
// - Bit set forces selected bit high
// - Bit clear forces selected bit low
// - Bit invert toggles selected bit
// - Bit test loads zero with inverse
// - Carry ANDed with selected bit
// - Carry ORed with selected bit
// - Carry XORed with selected bit
// - Inverted variants use complemented immediate-numbered bit
`include "alu_ops_map.vh"
module alu_datapath (
	input  wire        ref_clk_in,    // CPU clock, 200 MHz.
	input  wire        rst_in,        // Synchronous reset, active high.
	input  wire        start_in,      // One-cycle pulse: execute op now.
	input  wire [4:0]  op_code_in,    // Operation code.
	input  wire [1:0]  size_in,       // Operand size.
	input  wire [31:0] dest_in,       // Destination operand.
	input  wire [31:0] source_in,     // Source register or immediate.
	input  wire [2:0]  bit_imm_in,    // Bit number from immediate field.
	input  wire        bit_from_reg_in, // Take bit number from source low bits.
	input  wire [3:0]  flags_in,      // Current condition_flags.
	output reg  [31:0] result_out,    // Result to write back.
	output reg         write_out,     // Pulse: write result_out to destination.
	output reg  [3:0]  flags_out,     // Updated condition_flags.
	output reg         flags_write_out, // Pulse: flags_out is to be stored.
	output reg         done_out       // Pulse: operation finished.
);

	// Result, flags and strobes computed in one cycle.
	reg [31:0] res_next;
	reg [3:0]  flg_next;
	reg        wr_next;
	reg        fw_next;
	reg [32:0] diff;
	reg [31:0] quo;
	reg [31:0] rem;
	reg [31:0] sdvd;
	reg [31:0] sdvs;
	reg [2:0]  bnum;
	reg        sel_bit;
	reg        out_bit;
	reg        msb;

	// Mask a value to the operand width.
	function [31:0] fit;
		input [31:0] v;
		input [1:0]  sz;
		begin
			case (sz)
				`SIZE_BYTE: fit = {24'h000000, v[7:0]};
				`SIZE_WORD: fit = {16'h0000, v[15:0]};
				default:    fit = v;
			endcase
		end
	endfunction

	// Sign bit of a value at the operand width.
	function top_bit;
		input [31:0] v;
		input [1:0]  sz;
		begin
			case (sz)
				`SIZE_BYTE: top_bit = v[7];
				`SIZE_WORD: top_bit = v[15];
				default:    top_bit = v[31];
			endcase
		end
	endfunction

	// Place a bit at the top position of the operand width.
	function [31:0] at_top;
		input       b;
		input [1:0] sz;
		begin
			case (sz)
				`SIZE_BYTE: at_top = {24'h000000, b, 7'h00};
				`SIZE_WORD: at_top = {16'h0000, b, 15'h0000};
				default:    at_top = {b, 31'h00000000};
			endcase
		end
	endfunction

	// True for the carry bit operations that use the complement of the bit.
	// Only these lack a register-numbered form, so only they ignore the source.
	function inv_carry_op;
		input [4:0] op;
		begin
			case (op)
				`OP_INV_BIT_AND_CARRY: inv_carry_op = 1'b1;
				`OP_INV_BIT_OR_CARRY:  inv_carry_op = 1'b1;
				`OP_INV_BIT_XOR_CARRY: inv_carry_op = 1'b1;
				default:               inv_carry_op = 1'b0;
			endcase
		end
	endfunction

	// True for the shift and rotate group, which moves one bit per operation.
	// Its carry and overflow handling is shared, so the range is decoded here only.
	function shift_op;
		input [4:0] op;
		begin
			shift_op = (op >= `OP_ARITH_SHIFT_LEFT) && (op <= `OP_ROTATE_CARRY_RIGHT);
		end
	endfunction

	// True for operations whose N and Z follow the written result.
	// Compare and divide set their own N and Z; bit test sets Z, and the other bit operations leave both.
	function nz_op;
		input [4:0] op;
		begin
			nz_op = (op >= `OP_NEGATE) && (op <= `OP_ROTATE_CARRY_RIGHT);
		end
	endfunction

	// Combinational execution of the selected operation.
	always @* begin
		res_next = fit(dest_in, size_in);
		flg_next = flags_in;
		wr_next  = 1'b1;
		fw_next  = 1'b1;
		diff     = {1'b0, fit(dest_in, size_in)} - {1'b0, fit(source_in, size_in)};
		sdvd     = 32'h00000000;
		sdvs     = 32'h00000000;
		quo      = 32'h00000000;
		rem      = 32'h00000000;
		// Inverted carry variants have no register form, so the immediate is forced.
		bnum     = (bit_from_reg_in && !inv_carry_op(op_code_in)) ?
		           source_in[2:0] : bit_imm_in;
		sel_bit  = dest_in[bnum];
		out_bit  = 1'b0;
		msb      = top_bit(dest_in, size_in);
		// Every branch starts from the defaults above, so an op names only what it changes.
		case (op_code_in)
			`OP_SIGNED_DIVIDE: begin
				// Byte form divides 16 by 8, otherwise 32 by 16; rem sits in the upper half.
				if (size_in == `SIZE_BYTE) begin
					sdvd = {{16{dest_in[15]}}, dest_in[15:0]};
					sdvs = {{24{source_in[7]}}, source_in[7:0]};
				end else begin
					sdvd = dest_in;
					sdvs = {{16{source_in[15]}}, source_in[15:0]};
				end
				// Division by zero skips the divider, leaving quotient and remainder zero.
				// Most negative dividend over minus one overflows and simply truncates.
				if (sdvs != 32'h00000000) begin
					quo = $signed(sdvd) / $signed(sdvs);
					rem = $signed(sdvd) % $signed(sdvs);
				end
				if (size_in == `SIZE_BYTE) begin
					res_next = {dest_in[31:16], rem[7:0], quo[7:0]};
					flg_next[`FLAG_N] = quo[7];
					flg_next[`FLAG_Z] = (source_in[7:0] == 8'h00);
				end else begin
					res_next = {rem[15:0], quo[15:0]};
					flg_next[`FLAG_N] = quo[15];
					flg_next[`FLAG_Z] = (source_in[15:0] == 16'h0000);
				end
			end
			`OP_COMPARE_OP: begin
				// Destination unchanged; only flags follow the difference.
				wr_next = 1'b0;
				flg_next[`FLAG_C] = diff[32];
				flg_next[`FLAG_Z] = (fit(diff[31:0], size_in) == 32'h00000000);
				flg_next[`FLAG_N] = top_bit(diff[31:0], size_in);
				flg_next[`FLAG_V] = (msb != top_bit(source_in, size_in)) &&
				                    (top_bit(diff[31:0], size_in) != msb);
			end
			`OP_NEGATE: begin
				res_next = 32'h00000000 - dest_in;
				flg_next[`FLAG_V] = msb && (fit(res_next, size_in) == at_top(1'b1, size_in));
				flg_next[`FLAG_C] = (fit(dest_in, size_in) != 32'h00000000);
			end
			`OP_ZERO_EXTEND: begin
				res_next = (size_in == `SIZE_WORD) ? {24'h000000, dest_in[7:0]} :
				           {16'h0000, dest_in[15:0]};
				flg_next[`FLAG_V] = 1'b0;
			end
			`OP_SIGN_EXTEND: begin
				res_next = (size_in == `SIZE_WORD) ? {{24{dest_in[7]}}, dest_in[7:0]} :
				           {{16{dest_in[15]}}, dest_in[15:0]};
				flg_next[`FLAG_V] = 1'b0;
			end
			`OP_AND: res_next = dest_in & source_in;
			`OP_OR:  res_next = dest_in | source_in;
			`OP_XOR: res_next = dest_in ^ source_in;
			`OP_NOT: res_next = ~dest_in;
			`OP_ARITH_SHIFT_LEFT: begin
				out_bit = msb;
				res_next = {dest_in[30:0], 1'b0};
				flg_next[`FLAG_V] = msb ^ top_bit(res_next, size_in);
			end
			`OP_ARITH_SHIFT_RIGHT: begin
				out_bit = dest_in[0];
				res_next = (fit(dest_in, size_in) >> 1) | at_top(msb, size_in);
			end
			`OP_LOGIC_SHIFT_LEFT: begin
				out_bit = msb;
				res_next = {dest_in[30:0], 1'b0};
			end
			`OP_LOGIC_SHIFT_RIGHT: begin
				out_bit = dest_in[0];
				res_next = fit(dest_in, size_in) >> 1;
			end
			`OP_ROTATE_LEFT: begin
				out_bit = msb;
				res_next = {dest_in[30:0], msb};
			end
			`OP_ROTATE_RIGHT: begin
				out_bit = dest_in[0];
				res_next = (fit(dest_in, size_in) >> 1) | at_top(dest_in[0], size_in);
			end
			`OP_ROTATE_CARRY_LEFT: begin
				out_bit = msb;
				res_next = {dest_in[30:0], flags_in[`FLAG_C]};
			end
			`OP_ROTATE_CARRY_RIGHT: begin
				out_bit = dest_in[0];
				res_next = (fit(dest_in, size_in) >> 1) |
				           at_top(flags_in[`FLAG_C], size_in);
			end
			`OP_BIT_SET:    fw_next = 1'b0;
			`OP_BIT_CLEAR:  fw_next = 1'b0;
			`OP_BIT_INVERT: fw_next = 1'b0;
			`OP_BIT_TEST: begin
				wr_next = 1'b0;
				flg_next[`FLAG_Z] = ~sel_bit;
			end
			// Carry bit operations leave the operand alone and change carry only.
			`OP_BIT_AND_CARRY:     flg_next[`FLAG_C] = flags_in[`FLAG_C] & sel_bit;
			`OP_INV_BIT_AND_CARRY: flg_next[`FLAG_C] = flags_in[`FLAG_C] & ~sel_bit;
			`OP_BIT_OR_CARRY:      flg_next[`FLAG_C] = flags_in[`FLAG_C] | sel_bit;
			`OP_INV_BIT_OR_CARRY:  flg_next[`FLAG_C] = flags_in[`FLAG_C] | ~sel_bit;
			`OP_BIT_XOR_CARRY:     flg_next[`FLAG_C] = flags_in[`FLAG_C] ^ sel_bit;
			`OP_INV_BIT_XOR_CARRY: flg_next[`FLAG_C] = flags_in[`FLAG_C] ^ ~sel_bit;
			default: begin
				wr_next = 1'b0;
				fw_next = 1'b0;
			end
		endcase
		// Byte bit operations touch bits 7:0 only; bit numbers never exceed 7.
		if (op_code_in == `OP_BIT_SET)
			res_next = dest_in | (32'h00000001 << bnum);
		if (op_code_in == `OP_BIT_CLEAR)
			res_next = dest_in & ~(32'h00000001 << bnum);
		if (op_code_in == `OP_BIT_INVERT)
			res_next = dest_in ^ (32'h00000001 << bnum);
		if (op_code_in >= `OP_BIT_AND_CARRY)
			wr_next = 1'b0;
		// Operand bits above the size pass through from the destination. Word extends
		// act on a 16-bit register, so the upper half of the destination is kept too.
		// Divide lays out quotient and remainder itself and is left alone.
		if (op_code_in != `OP_SIGNED_DIVIDE)
			res_next = (dest_in & ~fit(32'hFFFFFFFF, size_in)) | fit(res_next, size_in);
		// Shift group: exactly one bit moves and its out bit lands in carry.
		if (shift_op(op_code_in)) begin
			flg_next[`FLAG_C] = out_bit;
			if (op_code_in != `OP_ARITH_SHIFT_LEFT)
				flg_next[`FLAG_V] = 1'b0;
		end
		// N and Z follow the result for logic, shift, negate and extend.
		if (nz_op(op_code_in)) begin
			flg_next[`FLAG_N] = top_bit(res_next, (op_code_in == `OP_ZERO_EXTEND ||
			                    op_code_in == `OP_SIGN_EXTEND) ? size_in : size_in);
			flg_next[`FLAG_Z] = (fit(res_next, size_in) == 32'h00000000);
			if (op_code_in >= `OP_AND && op_code_in <= `OP_NOT)
				flg_next[`FLAG_V] = 1'b0;
		end
	end

	// Registered outputs; strobes last one cycle after each start pulse.
	// Result and flags hold between operations so a slow write-back may sample them late.
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			result_out      <= 32'h00000000;
			write_out       <= 1'b0;
			flags_out       <= `FLAGS_RESET;
			flags_write_out <= 1'b0;
			done_out        <= 1'b0;
		end else begin
			write_out       <= start_in & wr_next;
			flags_write_out <= start_in & fw_next;
			done_out        <= start_in;
			if (start_in) begin
				result_out <= res_next;
				flags_out  <= flg_next;
			end
		end
	end

endmodule // alu_datapath

// ### sim/alu_datapath_properties.sv
`timescale 1ns/100ps
`include "alu_ops_map.vh"
module alu_datapath_properties (
	input wire        ref_clk_in,      // Clock.
	input wire        rst_in,          // Reset.
	input wire        start_in,        // Op strobe.
	input wire [4:0]  op_code_in,      // Op code.
	input wire [1:0]  size_in,         // Size.
	input wire [31:0] dest_in,         // Destination.
	input wire [31:0] source_in,       // Source.
	input wire [2:0]  bit_imm_in,      // Bit number.
	input wire        bit_from_reg_in, // Bit from source.
	input wire [3:0]  flags_in,        // Flags in.
	input wire [31:0] result_out,      // Result.
	input wire        write_out,       // Write strobe.
	input wire [3:0]  flags_out,       // Flags out.
	input wire        flags_write_out, // Flag strobe.
	input wire        done_out         // Done.
);
	// Selected bit of the byte operand, as the non-inverted bit ops see it.
	wire [2:0] bit_no  = bit_from_reg_in ? source_in[2:0] : bit_imm_in;
	wire       sel_bit = dest_in[bit_no];
	wire       go_long = start_in && size_in == `SIZE_LONG;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	a_and_long: assert property (go_long && op_code_in == `OP_AND |=>
		result_out == ($past(dest_in) & $past(source_in))) else $error("and result wrong");
	a_not_long: assert property (go_long && op_code_in == `OP_NOT |=>
		result_out == ~$past(dest_in)) else $error("not result wrong");
	a_neg_long: assert property (go_long && op_code_in == `OP_NEGATE |=>
		result_out == 32'h0 - $past(dest_in)) else $error("negate result wrong");
	a_zext_long: assert property (go_long && op_code_in == `OP_ZERO_EXTEND |=>
		result_out == ($past(dest_in) & 32'h0000FFFF)) else $error("zero extend wrong");
	a_shift_right_long: assert property (go_long && op_code_in == `OP_LOGIC_SHIFT_RIGHT |=>
		result_out == $past(dest_in) >> 1 && flags_out[`FLAG_C] == $past(dest_in[0]))
		else $error("logic shift right wrong");
	a_bit_set: assert property (start_in && op_code_in == `OP_BIT_SET |=>
		result_out[7:0] == ($past(dest_in[7:0]) | (8'h01 << $past(bit_no))) && !flags_write_out)
		else $error("bit set wrong");
	a_bit_test: assert property (start_in && op_code_in == `OP_BIT_TEST |=>
		flags_out[`FLAG_Z] == !$past(sel_bit) && !write_out) else $error("bit test wrong");
	a_carry_xor: assert property (start_in && op_code_in == `OP_BIT_XOR_CARRY |=>
		flags_out[`FLAG_C] == ($past(flags_in[`FLAG_C]) ^ $past(sel_bit))) else $error("xor carry wrong");
	a_compare_flags: assert property (start_in && op_code_in == `OP_COMPARE_OP |=>
		flags_write_out && !write_out) else $error("compare wrote result");
endmodule // alu_datapath_properties
bind alu_datapath alu_datapath_properties u_alu_datapath_properties (.ref_clk_in(ref_clk_in),
	.rst_in(rst_in), .start_in(start_in), .op_code_in(op_code_in), .size_in(size_in),
	.dest_in(dest_in), .source_in(source_in), .bit_imm_in(bit_imm_in),
	.bit_from_reg_in(bit_from_reg_in), .flags_in(flags_in), .result_out(result_out),
	.write_out(write_out), .flags_out(flags_out), .flags_write_out(flags_write_out),
	.done_out(done_out));

// ### sim/operand_store.sv
`timescale 1ns/100ps
module operand_store (
	input  wire        ref_clk_in,     // Clock.
	input  wire        rst_in,         // Reset.
	input  wire        load_in,        // Preload strobe.
	input  wire [31:0] load_dest_in,   // Preload operand.
	input  wire [3:0]  load_flags_in,  // Preload flags.
	input  wire        write_in,       // Result strobe.
	input  wire [31:0] result_in,      // Result.
	input  wire        flags_write_in, // Flag strobe.
	input  wire [3:0]  flags_new_in,   // New flags.
	output reg  [31:0] dest_out,       // Destination operand.
	output reg  [3:0]  flags_out       // Stored flags.
);
	// Write-backs land one edge after the strobe, so a following op reads the stored value.
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			dest_out <= 32'h0;
			flags_out <= 4'h0;
		end else if (load_in) begin
			dest_out <= load_dest_in;
			flags_out <= load_flags_in;
		end else begin
			if (write_in)
				dest_out <= result_in;
			if (flags_write_in)
				flags_out <= flags_new_in;
		end
	end
endmodule // operand_store

// ### sim/tb.sv
`timescale 1ns/100ps
`include "alu_ops_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	reg         ref_clk_in = 1'b0;
	reg         rst_in = 1'b1;
	reg         start_in = 1'b0;
	reg         bit_from_reg_in = 1'b0;
	reg         load_en = 1'b0;
	reg  [4:0]  op_code_in = 5'h00;
	reg  [1:0]  size_in = 2'h0;
	reg  [31:0] source_in = 32'h0;
	reg  [31:0] load_dest = 32'h0;
	reg  [2:0]  bit_imm_in = 3'h0;
	reg  [3:0]  load_flags = 4'h0;
	wire [31:0] dest_in, result_out;
	wire [3:0]  flags_in, flags_out;
	wire        write_out, flags_write_out, done_out;
	integer     n_mismatch = 0;
	integer     num_checks = 0;
	integer     k;
	alu_datapath u_alu_datapath (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .start_in(start_in),
		.op_code_in(op_code_in), .size_in(size_in), .dest_in(dest_in), .source_in(source_in),
		.bit_imm_in(bit_imm_in), .bit_from_reg_in(bit_from_reg_in), .flags_in(flags_in),
		.result_out(result_out), .write_out(write_out), .flags_out(flags_out),
		.flags_write_out(flags_write_out), .done_out(done_out));
	operand_store u_operand_store (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(load_en),
		.load_dest_in(load_dest), .load_flags_in(load_flags), .write_in(write_out),
		.result_in(result_out), .flags_write_in(flags_write_out), .flags_new_in(flags_out),
		.dest_out(dest_in), .flags_out(flags_in));
	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	task finish_test;
		begin
			$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// Preload operand and flags, issue one op, then wait a bounded time for the answer.
	task run(input [4:0] op, input [1:0] sz, input [31:0] d, input [31:0] s, input [2:0] bi,
		input br, input [3:0] f);
		integer i;
		begin
			@(posedge ref_clk_in);
			load_en <= 1'b1;
			load_dest <= d;
			load_flags <= f;
			@(posedge ref_clk_in);
			load_en <= 1'b0;
			start_in <= 1'b1;
			op_code_in <= op;
			size_in <= sz;
			source_in <= s;
			bit_imm_in <= bi;
			bit_from_reg_in <= br;
			@(posedge ref_clk_in);
			start_in <= 1'b0;
			#1;
			for (i = 0; i < 4 && done_out !== 1'b1; i++) begin
				@(posedge ref_clk_in);
				#1;
			end
			if (i == 4) begin
				n_mismatch++;
				finish_test();
			end
		end
	endtask
	task t_logic;
		begin
			run(`OP_AND, `SIZE_BYTE, 32'h123456F0, 32'h3C, 0, 0, 0);
			`CHK(result_out, 32'h12345630)
			`CHK({write_out, flags_write_out, done_out}, 3'h7)
			run(`OP_OR, `SIZE_LONG, 32'h0F0F0000, 32'h8000000F, 0, 0, 0);
			`CHK({result_out, flags_out[3]}, {32'h8F0F000F, 1'b1})
			run(`OP_XOR, `SIZE_WORD, 32'hAAAA1234, 32'h1234, 0, 0, 0);
			`CHK({result_out, flags_out[2]}, {32'hAAAA0000, 1'b1})
			run(`OP_NOT, `SIZE_LONG, 32'h0000FFFF, 0, 0, 0, 0);
			`CHK(result_out, 32'hFFFF0000)
			run(`OP_AND, `SIZE_LONG, 32'hF0F0A5A5, 32'h0FF0FFFF, 0, 0, 0);
			`CHK({result_out, flags_out[3:2]}, {32'h00F0A5A5, 2'b00})
		end
	endtask
	task t_arith;
		begin
			run(`OP_NEGATE, `SIZE_BYTE, 32'h1, 0, 0, 0, 0);
			`CHK({result_out, flags_out[3]}, {32'hFF, 1'b1})
			run(`OP_NEGATE, `SIZE_LONG, 32'h10, 0, 0, 0, 0);
			`CHK({result_out, flags_out[3], flags_out[0]}, {32'hFFFFFFF0, 2'b11})
			run(`OP_ZERO_EXTEND, `SIZE_LONG, 32'h12348000, 0, 0, 0, 0);
			`CHK(result_out, 32'h00008000)
			run(`OP_SIGN_EXTEND, `SIZE_LONG, 32'h12348000, 0, 0, 0, 0);
			`CHK(result_out, 32'hFFFF8000)
			run(`OP_SIGN_EXTEND, `SIZE_WORD, 32'hABCD0080, 0, 0, 0, 0);
			`CHK(result_out, 32'hABCDFF80)
			run(`OP_ZERO_EXTEND, `SIZE_WORD, 32'hABCDFF80, 0, 0, 0, 0);
			`CHK(result_out, 32'hABCD0080)
			run(`OP_COMPARE_OP, `SIZE_BYTE, 32'h1, 32'h2, 0, 0, 0);
			`CHK({write_out, flags_write_out, flags_out[3], flags_out[0]}, 4'hF & 4'h7)
			run(`OP_COMPARE_OP, `SIZE_LONG, 32'h5, 32'h5, 0, 0, 0);
			`CHK(flags_out[2], 1'b1)
			run(`OP_SIGNED_DIVIDE, `SIZE_BYTE, 32'hFFF9, 32'h2, 0, 0, 0);
			`CHK(result_out, 32'hFFFD)
			run(`OP_SIGNED_DIVIDE, `SIZE_WORD, 32'hFFFFFFF9, 32'h2, 0, 0, 0);
			`CHK(result_out, 32'hFFFFFFFD)
			run(`OP_SIGNED_DIVIDE, `SIZE_BYTE, 32'h56781234, 32'h0, 0, 0, 0);
			`CHK({result_out, flags_out[2]}, {32'h56780000, 1'b1})
		end
	endtask
	// Shift group, byte 81 with carry clear; every op moves one place and sets carry; then long rotate through carry clears it, long shift right.
	task t_shift;
		reg [63:0] exp;
		begin
			exp = 64'h02C0024003C00240;
			for (k = 0; k < 8; k++) begin
				run(`OP_ARITH_SHIFT_LEFT + k, `SIZE_BYTE, 32'h81, 0, 0, 0, 0);
				`CHK({result_out[7:0], flags_out[0]}, {exp[63 - 8 * k -: 8], 1'b1})
			end
			run(`OP_ROTATE_CARRY_RIGHT, `SIZE_LONG, 32'h0, 0, 0, 0, 4'h1);
			`CHK({result_out, flags_out[0]}, {32'h80000000, 1'b0})
			run(`OP_LOGIC_SHIFT_RIGHT, `SIZE_LONG, 32'h80000003, 0, 0, 0, 0);
			`CHK({result_out, flags_out[0]}, {32'h40000001, 1'b1})
		end
	endtask
	task t_bits;
		begin
			run(`OP_BIT_SET, `SIZE_BYTE, 32'hA5, 0, 1, 0, 0);
			`CHK(result_out[7:0], 8'hA7)
			run(`OP_BIT_CLEAR, `SIZE_BYTE, 32'hA5, 32'hF8, 7, 1, 0);
			`CHK(result_out[7:0], 8'hA4)
			run(`OP_BIT_INVERT, `SIZE_BYTE, 32'hA5, 0, 7, 0, 0);
			`CHK(result_out[7:0], 8'h25)
			run(`OP_BIT_TEST, `SIZE_BYTE, 32'hA5, 32'h5, 6, 1, 0);
			`CHK({flags_out[2], write_out}, 2'b00)
			// Plain forms take bit 0 (set) from the source, inverted ones bit 1 (clear) from
			// the immediate, so each sees a 1; carry is set for the first six, clear after.
			for (k = 0; k < 12; k++) begin
				run(`OP_BIT_AND_CARRY + k % 6, `SIZE_BYTE, 32'hA5, 0, 1, 1, k < 6);
				`CHK(flags_out[0], 12'hF0F >> (11 - k) & 1'b1)
			end
		end
	endtask
	// Main sequence: reset for three cycles, then every scenario in turn.
	initial begin
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_logic();
		t_arith();
		t_shift();
		t_bits();
		finish_test();
	end
endmodule // tb
